// >>> verilog/amr_pkg.sv
// constants, field layouts and carrier types of the mode word and data-ready control block
// Summary of operation
// - word size field bits 9:8: 00b gives 16-bit words, 01b gives 24-bit words (default)
// - code 10b pads 32-bit words with low zeros, 11b sign-extends into top bits
// - mode bit 4 enables the serial timeout when set; enabled after reset
// - bits 3:2 pick ready source: lagging (default), OR of enabled, or leading channel
// - no data pending: bit 1 clear drives ready pin high, set floats it
// - data available: bit 0 clear holds pin low, set gives fixed low pulse
// - clock configuration register sits at address 3h and resets to 0F0Eh
package amr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;

  // register map, 6-bit word addresses
  localparam logic [5:0]  CLOCK_ADDR  = 6'h03;
  localparam logic [5:0]  MODE_ADDR   = 6'h02;
  localparam logic [15:0] CLOCK_RESET = 16'h0F0E;
  localparam logic [15:0] CLOCK_WMASK = 16'h0FFF;
  localparam logic [15:0] MODE_RESET  = 16'h0110;
  localparam logic [15:0] MODE_WMASK  = 16'h03FF;
  localparam int unsigned CH_EN_LSB   = 8;

  // word size codes
  localparam logic [1:0] WS_16      = 2'h0;
  localparam logic [1:0] WS_24      = 2'h1;
  localparam logic [1:0] WS_32_PAD  = 2'h2;
  localparam logic [1:0] WS_32_SIGN = 2'h3;

  // ready source codes; both upper codes select the leading channel
  localparam logic [1:0] SRC_LAG = 2'h0;
  localparam logic [1:0] SRC_OR  = 2'h1;

  // serial frame: 16-bit command then 16-bit data, msb first
  localparam int unsigned CMD_WR_BIT = 15;
  localparam int unsigned ADDR_W     = 6;
  localparam logic [4:0]  LAST_BIT   = 5'h0F;
  localparam logic [4:0]  BIT_ONE    = 5'h01;

  // timing
  localparam int unsigned PULSE_NS    = 16;
  localparam int unsigned PULSE_CYC   = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMEOUT_NS  = 16384;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [5:0] upper;
    logic [1:0] word_size_sel;
    logic [2:0] reserved;
    logic       timeout_en;
    logic [1:0] ready_source_sel;
    logic       ready_idle_float;
    logic       ready_pulse_format;
  } amr_mode_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } amr_spi_t;

  typedef enum logic [2:0] {
    FR_IDLE = 3'b001,
    FR_CMD  = 3'b010,
    FR_DATA = 3'b100
  } amr_frame_t;

endpackage

// >>> verilog/amr_word_fmt.sv
// output word formatter for the selected word size
module amr_word_fmt (
  // sample in
  input  wire logic [23:0] sample_i,
  input  wire logic [1:0]  word_size_sel_i,
  // formatted word, right aligned except the padded 32-bit code, which puts the sample in bits 31:8
  output logic      [31:0] word_o
);

  wire logic [31:0] w16   = {16'h0000, sample_i[23:8]};
  wire logic [31:0] w24   = {8'h00, sample_i};
  wire logic [31:0] wpad  = {sample_i, 8'h00};
  wire logic [31:0] wsign = {{8{sample_i[23]}}, sample_i};

  // 16-bit keeps the top of the sample, dropping the low byte
  assign word_o = (word_size_sel_i == amr_pkg::WS_16)     ? w16  :
                  (word_size_sel_i == amr_pkg::WS_24)     ? w24  :
                  (word_size_sel_i == amr_pkg::WS_32_PAD) ? wpad :
                                                            wsign;

endmodule

// >>> verilog/amr_mode_ready_ctrl.sv
// mode and clock registers over the serial port, word formatting and data-ready pin control
module amr_mode_ready_ctrl #(
  parameter int unsigned TIMEOUT_CYC = amr_pkg::TIMEOUT_CYC,
  parameter int unsigned N_CH        = 4
) (
  // clock and reset
  input  wire logic            REF_CLK_I,
  input  wire logic            NRST_I,
  // serial port
  input  wire logic            SPI_CS_N_I,
  input  wire logic            SPI_SCLK_I,
  input  wire logic            SPI_SDI_I,
  output logic                 SPI_SDO_O,
  output logic                 SPI_SDO_OE_O,
  // converter side
  input  wire logic [N_CH-1:0] CH_READY_I,
  input  wire logic [23:0]     CH_SAMPLE_I,
  output logic      [31:0]     SAMPLE_WORD_O,
  // data-ready pin
  output logic                 SAMPLE_READY_O,
  output logic                 SAMPLE_READY_OE_O
);

  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [2:0]  PW = 3'(amr_pkg::PULSE_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0]        rst_s_q;
  wire logic         rst_n = rst_s_q[1];

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) rst_s_q <= 2'h0;
    else         rst_s_q <= {rst_s_q[0], 1'b1};
  end

  amr_pkg::amr_spi_t s1_q, s2_q, s3_q, filt_q, prev_q;
  wire amr_pkg::amr_spi_t pin_now = '{cs_n: SPI_CS_N_I, sclk: SPI_SCLK_I, sdi: SPI_SDI_I};
  wire logic [2:0]        agree   = ~(s2_q ^ s3_q);
  wire amr_pkg::amr_spi_t filt_d  = amr_pkg::amr_spi_t'((s3_q & agree) | (filt_q & ~agree));

  // idle high values so leaving reset on an idle bus does not look like an edge
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= 3'h6;
      s2_q   <= 3'h6;
      s3_q   <= 3'h6;
      filt_q <= 3'h6;
      prev_q <= 3'h6;
    end else begin
      s1_q   <= pin_now;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  wire logic cs_high   = filt_q.cs_n;
  wire logic cs_fall   = prev_q.cs_n & ~filt_q.cs_n;
  wire logic sclk_rise = filt_q.sclk & ~prev_q.sclk;
  wire logic sclk_fall = ~filt_q.sclk & prev_q.sclk;

  //////////////////////////////////////////////////////////////////////////////
  // frame engine
  amr_pkg::amr_frame_t state_q, state_d;
  logic [4:0]          bit_q, bit_d;
  logic [15:0]         shift_q, cmd_q, sdo_sh_q, rdata;
  logic [TW-1:0]       idle_q;
  logic                sdo_q, sdo_oe_q;
  amr_pkg::amr_mode_t  mode_q;
  logic [15:0]         clk_reg_q;

  wire logic [15:0] in_word  = {shift_q[14:0], filt_q.sdi};
  wire logic        active   = (state_q == amr_pkg::FR_CMD) || (state_q == amr_pkg::FR_DATA);
  wire logic        last_bit = sclk_rise && (bit_q == amr_pkg::LAST_BIT);
  wire logic        cmd_done = (state_q == amr_pkg::FR_CMD) && last_bit;
  wire logic        wr_done  = (state_q == amr_pkg::FR_DATA) && last_bit && cmd_q[amr_pkg::CMD_WR_BIT];
  wire logic [5:0]  wr_addr  = cmd_q[amr_pkg::ADDR_W-1:0];
  wire logic [5:0]  rd_addr  = in_word[amr_pkg::ADDR_W-1:0];
  wire logic        sclk_any = sclk_rise | sclk_fall;
  // stall counted only mid-frame; edges restart the count
  wire logic        timeout_hit = mode_q.timeout_en && active && !sclk_any &&
                                  (idle_q == TW'(TIMEOUT_CYC));

  always_comb begin
    if (rd_addr == amr_pkg::CLOCK_ADDR)     rdata = clk_reg_q;
    else if (rd_addr == amr_pkg::MODE_ADDR) rdata = mode_q;
    else                                    rdata = 16'h0000;
  end

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    if (cs_high) begin
      state_d = amr_pkg::FR_IDLE;
    end else if (cs_fall || timeout_hit) begin
      state_d = amr_pkg::FR_CMD;
      bit_d   = 5'h00;
    end else begin
      case (state_q)
        amr_pkg::FR_CMD: begin
          if (last_bit) begin
            state_d = amr_pkg::FR_DATA;
            bit_d   = 5'h00;
          end else if (sclk_rise) begin
            bit_d = bit_q + amr_pkg::BIT_ONE;
          end
        end
        amr_pkg::FR_DATA: begin
          if (last_bit) state_d = amr_pkg::FR_IDLE;
          else if (sclk_rise) bit_d = bit_q + amr_pkg::BIT_ONE;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= amr_pkg::FR_IDLE;
      bit_q   <= 5'h00;
      idle_q  <= '0;
    end else begin
      state_q <= state_d;
      bit_q   <= bit_d;
      idle_q  <= (!active || sclk_any || timeout_hit) ? '0 : idle_q + TW'(1);
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      shift_q  <= 16'h0000;
      cmd_q    <= 16'h0000;
      sdo_sh_q <= 16'h0000;
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      if (sclk_rise) shift_q <= in_word;
      if (cmd_done)  cmd_q <= in_word;
      if (cmd_done) begin
        sdo_sh_q <= rdata;
      end else if (sclk_fall && state_q == amr_pkg::FR_DATA) begin
        sdo_q    <= sdo_sh_q[15];
        sdo_sh_q <= {sdo_sh_q[14:0], 1'b0};
      end
      sdo_oe_q <= ~cs_high;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; mode bits above 9 belong to other logic and stay zero here
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      clk_reg_q <= amr_pkg::CLOCK_RESET;
      mode_q    <= amr_pkg::MODE_RESET;
    end else if (wr_done) begin
      if (wr_addr == amr_pkg::CLOCK_ADDR) clk_reg_q <= in_word & amr_pkg::CLOCK_WMASK;
      // reserved 7:5 is stored as written; the host keeps it zero
      if (wr_addr == amr_pkg::MODE_ADDR)  mode_q <= in_word & amr_pkg::MODE_WMASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ready source selection
  wire logic [N_CH-1:0] chan_en  = clk_reg_q[amr_pkg::CH_EN_LSB +: N_CH];
  wire logic [N_CH-1:0] hit      = CH_READY_I & chan_en;
  logic      [N_CH-1:0] fired_q;
  wire logic            seen_all = (((fired_q | hit) & chan_en) == chan_en);
  wire logic            lag_ev   = (|hit) && seen_all;
  wire logic            lead_ev  = (|hit) && ((fired_q & chan_en) == '0);
  wire logic            or_ev    = |hit;
  wire logic            ev       = (mode_q.ready_source_sel == amr_pkg::SRC_LAG) ? lag_ev :
                                   (mode_q.ready_source_sel == amr_pkg::SRC_OR)  ? or_ev  :
                                                                                   lead_ev;
  wire logic [31:0]     fmt_word;

  amr_word_fmt u_fmt (
    .sample_i        (CH_SAMPLE_I),
    .word_size_sel_i (mode_q.word_size_sel),
    .word_o          (fmt_word)
  );

  logic       pending_q, rdy_q, rdy_oe_q;
  logic [2:0] pulse_q;
  logic [31:0] word_q;
  // pulse runs its full length even if the host starts reading early
  wire logic  ready_low = (pulse_q != 3'h0) || (pending_q && !mode_q.ready_pulse_format);

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      fired_q   <= '0;
      pending_q <= 1'b0;
      pulse_q   <= 3'h0;
      word_q    <= 32'h0000_0000;
      rdy_q     <= 1'b1;
      rdy_oe_q  <= 1'b1;
    end else begin
      // a round closes once every enabled channel has reported
      fired_q   <= lag_ev ? '0 : (fired_q | hit);
      // new data beats the clear of a starting frame
      pending_q <= ev ? 1'b1 : (cs_fall ? 1'b0 : pending_q);
      pulse_q   <= (ev && mode_q.ready_pulse_format) ? PW : ((pulse_q != 3'h0) ? pulse_q - 3'h1 : 3'h0);
      if (ev) word_q <= fmt_word;
      rdy_q     <= ~ready_low;
      rdy_oe_q  <= ready_low | ~mode_q.ready_idle_float;
    end
  end

  assign SPI_SDO_O         = sdo_q;
  assign SPI_SDO_OE_O      = sdo_oe_q;
  assign SAMPLE_WORD_O     = word_q;
  assign SAMPLE_READY_O    = rdy_q;
  assign SAMPLE_READY_OE_O = rdy_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  a_word_short_zero: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    ev && mode_q.word_size_sel == amr_pkg::WS_16 |=> SAMPLE_WORD_O == {16'h0000, $past(CH_SAMPLE_I[23:8])})
    else $error("16-bit word wrong");
  a_word_pad_low: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    ev && mode_q.word_size_sel == amr_pkg::WS_32_PAD |=> SAMPLE_WORD_O == {$past(CH_SAMPLE_I), 8'h00})
    else $error("padded word wrong");
  a_word_sign_ext: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    ev && mode_q.word_size_sel == amr_pkg::WS_32_SIGN |=>
      SAMPLE_WORD_O == {{8{$past(CH_SAMPLE_I[23])}}, $past(CH_SAMPLE_I)})
    else $error("sign extension wrong");
  a_timeout_restart: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    timeout_hit && !cs_high && !cs_fall |=> state_q == amr_pkg::FR_CMD && bit_q == 5'h00)
    else $error("stalled frame not dropped");
  a_timeout_off: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    !mode_q.timeout_en && active && !sclk_any && !cs_high && !cs_fall |=>
      state_q == $past(state_q) && bit_q == $past(bit_q))
    else $error("timeout fired while disabled");
  a_ready_or_src: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    mode_q.ready_source_sel == amr_pkg::SRC_OR && (|hit) |=> pending_q)
    else $error("or source missed a channel");
  a_idle_float: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    !ready_low && mode_q.ready_idle_float |=> !SAMPLE_READY_OE_O && SAMPLE_READY_O)
    else $error("idle pin not floated");
  a_hold_low: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    pending_q && !mode_q.ready_pulse_format |=> SAMPLE_READY_OE_O && !SAMPLE_READY_O)
    else $error("ready not held low");
  a_pulse_len: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    ev && mode_q.ready_pulse_format && pulse_q == 3'h0 ##1 (!ev && mode_q.ready_pulse_format) [*5] |->
      !SAMPLE_READY_O && !$past(SAMPLE_READY_O, 1) && !$past(SAMPLE_READY_O, 2) && !$past(SAMPLE_READY_O, 3)
      ##1 SAMPLE_READY_O)
    else $error("ready pulse length wrong");
  a_clock_rsvd: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
    wr_done && wr_addr == amr_pkg::CLOCK_ADDR |=> clk_reg_q == ($past(in_word) & amr_pkg::CLOCK_WMASK))
    else $error("clock register write wrong");

endmodule

// >>> verification/amr_host_model.sv
// host serial controller model that drives the register port of the block
module amr_host_model (
  // clock used for pacing only
  input  wire logic clk_i,
  // serial lines
  input  wire logic sdo_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    sdi_o  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one bit: 80 ns serial clock, data set on the fall, taken on the rise
  task automatic bit_x(input logic b, output logic r);
    repeat (10) @(posedge clk_i);
    #1 sclk_o = 1'b0;
    sdi_o = b;
    repeat (10) @(posedge clk_i);
    #1 r = sdo_i;
    sclk_o = 1'b1;
  endtask

  // optional stray bits and stall first, then a whole 32-bit frame
  task automatic frame(input logic [31:0] tx, input int nbits, input int stall, output logic [15:0] rd);
    logic r;
    rd = 16'h0000;
    @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    for (int j = 0; j < nbits; j++) begin
      bit_x(1'b1, r);
    end
    repeat (stall) @(posedge clk_i);
    for (int i = 0; i < 32; i++) begin
      bit_x(tx[31-i], r);
      if (i > 15) rd = {rd[14:0], r};
    end
    repeat (10) @(posedge clk_i);
    #1 cs_n_o = 1'b1;
    // released data line must not keep its last level
    sdi_o = ~sdi_o;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// >>> verification/tb.sv
// self-checking bench for the mode word and data-ready control block
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned TO_CYC = 64;
  logic        clk;
  logic        rst_n;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        rdy;
  logic        rdy_oe;
  logic [3:0]  ch_rdy;
  logic [23:0] smp;
  logic [31:0] word;
  logic [15:0] rd;
  int          miscompares;
  int          tests_run;

  amr_mode_ready_ctrl #(.TIMEOUT_CYC(TO_CYC), .N_CH(4)) dut_u (
    .REF_CLK_I(clk), .NRST_I(rst_n), .SPI_CS_N_I(cs_n), .SPI_SCLK_I(sclk), .SPI_SDI_I(sdi),
    .SPI_SDO_O(sdo), .SPI_SDO_OE_O(sdo_oe), .CH_READY_I(ch_rdy), .CH_SAMPLE_I(smp),
    .SAMPLE_WORD_O(word), .SAMPLE_READY_O(rdy), .SAMPLE_READY_OE_O(rdy_oe));
  // an undriven data line reads inverted, so a late or missing enable corrupts reads
  amr_host_model host_u (.clk_i(clk), .sdo_i(sdo_oe ? sdo : ~sdo), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [15:0] mode_w(logic [1:0] ws, logic to, logic [1:0] src, logic flt, logic fm);
    return {6'h00, ws, 3'h0, to, src, flt, fm};
  endfunction

  function automatic logic [31:0] fmt_w(logic [1:0] ws, logic [23:0] s);
    case (ws)
      2'h0: return {16'h0000, s[23:8]};
      2'h1: return {8'h00, s};
      2'h2: return {s, 8'h00};
      default: return {{8{s[23]}}, s};
    endcase
  endfunction

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host_u.frame({1'b1, 9'h000, a, d}, 0, 0, rd);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [15:0] exp, input string nm);
    host_u.frame({1'b0, 9'h000, a, 16'h0000}, 0, 0, rd);
    chk(nm, {16'h0000, exp}, {16'h0000, rd});
  endtask

  // one-cycle channel event with a fresh random sample
  task automatic ev(input logic [3:0] m);
    @(posedge clk);
    #1 ch_rdy = m;
    smp = 24'($urandom);
    @(posedge clk);
    #1 ch_rdy = 4'h0;
  endtask

  task automatic after(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    tests_run = 0;
    rst_n = 1'b0;
    ch_rdy = 4'h0;
    smp = 24'h000000;
    void'($urandom(44));
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    after(8);
    chk("ready idle", 32'h3, {29'h0, sdo_oe, rdy, rdy_oe});
    rdc(6'h03, 16'h0F0E, "clock reset");
    rdc(amr_pkg::MODE_ADDR, 16'h0110, "mode reset");
    rdc(6'h15, 16'h0000, "unmapped read");
    wr(6'h03, 16'hFFFF);
    rdc(6'h03, 16'h0FFF, "clock mask");
    wr(6'h03, 16'h0F0E);
    // stray bits then a stall past the window must resync the frame
    host_u.frame({16'h0003, 16'h0000}, 5, TO_CYC + 20, rd);
    chk("timeout resync", 32'h0F0E, {16'h0000, rd});
    // every word size, OR source so one channel is enough
    for (int ws = 0; ws < 4; ws++) begin
      wr(amr_pkg::MODE_ADDR, mode_w(ws[1:0], 1'b1, amr_pkg::SRC_OR, 1'b0, 1'b0));
      ev(4'h1 << ws);
      after(2);
      chk("word", fmt_w(ws[1:0], smp), word);
      chk("ready low", 32'h1, {31'h0, rdy_oe & ~rdy});
      after(6);
      chk("ready held", 32'h0, {31'h0, rdy});
    end
    wr(amr_pkg::MODE_ADDR, mode_w(2'h1, 1'b1, amr_pkg::SRC_OR, 1'b1, 1'b1));
    chk("float idle", 32'h0, {30'h0, sdo_oe, rdy_oe});
    ev(4'h8);
    after(2);
    chk("pulse low", 32'h1, {31'h0, rdy_oe & ~rdy});
    after(4);
    chk("pulse end", 32'h0, {31'h0, rdy_oe});
    // lagging, then both leading codes, each after a completed round
    for (int s = 0; s < 3; s++) begin
      wr(amr_pkg::MODE_ADDR, mode_w(2'h1, 1'b1, (s == 0) ? amr_pkg::SRC_LAG : 2'(s + 1), 1'b0, 1'b0));
      ev(4'hF);
      wr(6'h15, 16'hFFFF);
      ev(4'h4);
      after(4);
      chk("source first", (s == 0) ? 32'h0 : 32'h1, {31'h0, ~rdy});
      ev(4'hB);
      after(4);
      chk("source round", 32'h1, {31'h0, ~rdy});
    end
    rdc(6'h15, 16'h0000, "unmapped write");
    wr(amr_pkg::MODE_ADDR, mode_w(2'h1, 1'b0, amr_pkg::SRC_LAG, 1'b0, 1'b0));
    rdc(amr_pkg::MODE_ADDR, 16'h0100, "timeout off");
    // timeout off: stray bits stay counted, so the frame becomes a write to an unmapped address
    host_u.frame({16'h0003, 16'h0000}, 5, TO_CYC + 20, rd);
    chk("no resync", 32'h0, {16'h0000, rd});
    finish_test();
  end

  // whole run is near 20 frames of about 700 cycles
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule
